// File: src/aecer_regs.sv
// correctable error status, mask and capability registers on ahb-lite
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
// Overview of operation
// - receiver error sets sticky status bit 0; write one clears; reset zero
// - bad tlp sets sticky status bit 6; write one clears; reset zero
// - bad dllp sets sticky status bit 7; write one clears; reset zero
// - replay number rollover sets sticky status bit 8; reset zero
// - replay timer timeout sets sticky status bit 12; reset zero
// - advisory non-fatal error sets sticky status bit 13; reset zero
// - mask bit 0 blocks receiver error logging and message; reset zero
// - mask bit 6 blocks bad tlp logging and message; reset zero
// - mask bit 7 blocks bad dllp logging and message; reset zero
// - mask bit 8 blocks replay rollover logging and message; reset zero
// - mask bit 12 blocks replay timeout logging and message; reset zero
// - mask bit 13 blocks advisory logging and message; resets to one
// - bits 4:0 hold first uncorrectable error position, sticky, reset zero
// - bit 5 reads one, ecrc generation capable
// - sticky bit 6 enables ecrc generation; reset zero
// - bit 7 reads one, ecrc check capable
// - sticky bit 8 enables ecrc checking; reset zero
// - header log holds four sticky words, big-endian header bytes
module aecer_regs
    import aecer_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // event pulses from link and transaction layers
    input  wire aecer_evt_s  evt,
    input  wire logic [127:0] evt_hdr,
    input  wire logic        unc_first,
    input  wire logic [4:0]  unc_first_pos,
    // toward the message, ecrc and interrupt logic
    output logic             err_msg,
    output logic             ecrc_gen_en,
    output logic             ecrc_chk_en,
    output logic             irq
);
    typedef struct packed {
        logic [31:0]  status;
        logic [31:0]  mask;
        logic [4:0]   fep;
        logic         fep_valid;
        logic         gen_en;
        logic         chk_en;
        aecer_hdr_s   hlog;
        logic [31:0]  irq_stat;
        logic [31:0]  irq_mask;
        logic         dp_act;
        logic         dp_write;
        logic [11:0]  dp_addr;
        logic [31:0]  rdata;
        logic         msg;
        logic         irq;
    } aecer_state_s;

    aecer_state_s st;
    aecer_state_s next_st;

    function automatic logic [31:0] evt_vec(input aecer_evt_s e);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[BIT_RX_ERR]      = e.rx_err;
        v[BIT_BAD_TLP]     = e.bad_tlp;
        v[BIT_BAD_DLLP]    = e.bad_dllp;
        v[BIT_REPLAY_ROLL] = e.replay_roll;
        v[BIT_REPLAY_TMO]  = e.replay_tmo;
        v[BIT_ADVISORY]    = e.advisory;
        return v;
    endfunction

    // header arrives with byte 0 in the top bits; kept as is so reads stay big-endian
    function automatic logic [31:0] be_word(input logic [31:0] w);
        return w;
    endfunction

    logic [31:0] ev;
    logic [31:0] unmasked;
    logic [31:0] capctl;
    logic [31:0] wmask;
    logic        take;
    logic        rd_now;

    always_comb begin
        next_st  = st;
        ev       = evt_vec(evt) & COR_IMPL;
        unmasked = ev & ~st.mask;
        take     = hsel && hready && (htrans == HTRANS_NONSEQ);
        capctl   = 32'h0000_0000;
        capctl[FEP_LSB +: FEP_W] = st.fep;
        capctl[GEN_CAP_BIT] = 1'b1;
        capctl[GEN_EN_BIT]  = st.gen_en;
        capctl[CHK_CAP_BIT] = 1'b1;
        capctl[CHK_EN_BIT]  = st.chk_en;
        wmask  = 32'h0000_0000;
        rd_now = 1'b0;

        // data phase of a write; bus writes act before hardware sets below
        if (st.dp_act && st.dp_write) begin
            case (st.dp_addr)
                OFF_STATUS: begin
                    next_st.status = st.status & ~(hwdata & COR_IMPL);
                end
                OFF_MASK: begin
                    next_st.mask = hwdata & COR_IMPL;
                end
                OFF_CAPCTL: begin
                    next_st.gen_en = hwdata[GEN_EN_BIT];
                    next_st.chk_en = hwdata[CHK_EN_BIT];
                end
                OFF_IRQ_MASK: begin
                    next_st.irq_mask = hwdata & COR_IMPL;
                end
                default: begin
                    wmask = 32'h0000_0000;
                end
            endcase
        end

        // address phase: read data prepared now, stands in the next cycle
        next_st.dp_act   = take;
        next_st.dp_write = take && hwrite;
        next_st.dp_addr  = haddr;
        if (take && !hwrite) begin
            rd_now = 1'b1;
            case ({haddr[11:2], 2'b00})
                OFF_STATUS:       next_st.rdata = st.status;
                OFF_MASK:         next_st.rdata = st.mask;
                OFF_CAPCTL:       next_st.rdata = capctl;
                OFF_HDR0:         next_st.rdata = be_word(st.hlog.hdr[127:96]);
                OFF_HDR0 + 12'h4: next_st.rdata = be_word(st.hlog.hdr[95:64]);
                OFF_HDR0 + 12'h8: next_st.rdata = be_word(st.hlog.hdr[63:32]);
                OFF_HDR0 + 12'hc: next_st.rdata = be_word(st.hlog.hdr[31:0]);
                OFF_IRQ_STAT: begin
                    next_st.rdata = st.irq_stat;
                    // read clears; events of this very cycle survive below
                    next_st.irq_stat = 32'h0000_0000;
                end
                OFF_IRQ_MASK:     next_st.rdata = st.irq_mask;
                default:          next_st.rdata = 32'h0000_0000;
            endcase
        end else begin
            next_st.rdata = 32'h0000_0000;
        end

        // hardware sets win over software clears
        next_st.status   = next_st.status | ev;
        next_st.irq_stat = next_st.irq_stat | ev;

        // only unmasked events log a header and raise a message
        next_st.msg = |unmasked;
        if ((|unmasked) && !st.hlog.valid) begin
            next_st.hlog.valid = 1'b1;
            next_st.hlog.hdr   = evt_hdr;
        end

        // first error pointer latches once until the sticky reset
        if (unc_first && !st.fep_valid) begin
            next_st.fep       = unc_first_pos;
            next_st.fep_valid = 1'b1;
        end

        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.status    <= STATUS_RST;
            st.mask      <= MASK_RST;
            st.fep       <= FEP_RST;
            st.fep_valid <= 1'b0;
            st.gen_en    <= 1'b0;
            st.chk_en    <= 1'b0;
            st.hlog      <= '0;
            st.irq_stat  <= 32'h0000_0000;
            st.irq_mask  <= 32'h0000_0000;
            st.dp_act    <= 1'b0;
            st.dp_write  <= 1'b0;
            st.dp_addr   <= 12'h000;
            st.rdata     <= 32'h0000_0000;
            st.msg       <= 1'b0;
            st.irq       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata      = st.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign err_msg     = st.msg;
    assign ecrc_gen_en = st.gen_en;
    assign ecrc_chk_en = st.chk_en;
    assign irq         = st.irq;
endmodule
`default_nettype wire

// File: src/aecer_pkg.sv
// package for the correctable error register bank
`default_nettype none
package aecer_pkg;
    localparam logic [11:0] OFF_STATUS   = 12'h110;
    localparam logic [11:0] OFF_MASK     = 12'h114;
    localparam logic [11:0] OFF_CAPCTL   = 12'h118;
    localparam logic [11:0] OFF_HDR0     = 12'h11c;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h200;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h204;
    localparam logic [11:0] OFF_UNC_STAT = 12'h208;

    localparam int BIT_RX_ERR   = 0;
    localparam int BIT_BAD_TLP  = 6;
    localparam int BIT_BAD_DLLP = 7;
    localparam int BIT_REPLAY_ROLL = 8;
    localparam int BIT_REPLAY_TMO  = 12;
    localparam int BIT_ADVISORY    = 13;
    localparam logic [31:0] COR_IMPL  = 32'h0000_31c1;

    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST   = 32'h0000_2000;

    localparam int FEP_LSB = 0;
    localparam int FEP_W   = 5;
    localparam int GEN_CAP_BIT = 5;
    localparam int GEN_EN_BIT  = 6;
    localparam int CHK_CAP_BIT = 7;
    localparam int CHK_EN_BIT  = 8;
    localparam logic [4:0] FEP_RST = 5'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // one correctable event per status bit position
    typedef struct packed {
        logic rx_err;
        logic bad_tlp;
        logic bad_dllp;
        logic replay_roll;
        logic replay_tmo;
        logic advisory;
    } aecer_evt_s;

    // header captured together with a logged event
    typedef struct packed {
        logic         valid;
        logic [127:0] hdr;
    } aecer_hdr_s;
endpackage
`default_nettype wire

// File: verification/aecer_rc_model.sv
// root complex stand-in counting error messages
`default_nettype none
module aecer_rc_model (
    // link side
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic err_msg,
    // observation
    output int        n_msg
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_msg <= 0;
        end else if (err_msg) begin
            n_msg <= n_msg + 1;
        end
    end
endmodule
`default_nettype wire

// File: verification/aecer_regs_chk.sv
// port checker for the correctable error register bank
`default_nettype none
module aecer_regs_chk
    import aecer_pkg::*;
(
    // bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // events and outputs
    input wire aecer_evt_s  evt,
    input wire logic        err_msg,
    input wire logic        ecrc_gen_en,
    input wire logic        irq
);
    logic        rd_q;
    logic        wr_q;
    logic [11:0] a_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 12'h000;
        end else begin
            rd_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
            wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            a_q  <= haddr;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence cap_rd;
        rd_q && a_q == OFF_CAPCTL;
    endsequence
    sequence st_rd;
        rd_q && a_q == OFF_STATUS;
    endsequence
    ready_high_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    idle_data_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata off phase");
    cap_bits_a:
        assert property (cap_rd |-> hrdata[7] && hrdata[5] && hrdata[31:9] == 23'h0)
        else $error("capability bits wrong");
    stat_rsvd_a:
        assert property (st_rd |-> (hrdata & ~COR_IMPL) == 32'h0) else $error("status rsvd set");
    msg_cause_a:
        assert property (err_msg |-> $past(evt) != 6'h00) else $error("message without event");
    irq_cause_a:
        assert property ($rose(irq) |-> $past(evt) != 6'h00 || $past(wr_q) || $past(wr_q, 2))
        else $error("irq without cause");
    gen_update_a:
        assert property ($changed(ecrc_gen_en) |-> $past(wr_q) || $past(wr_q, 2))
        else $error("ecrc enable moved alone");
endmodule
`default_nettype wire

// File: verification/aer_correctable_error_regs_tb_top.sv
// bench for the correctable error register bank
`default_nettype none
module aer_correctable_error_regs_tb_top
    import aecer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, unc_first = 1'b0;
    logic [11:0]  haddr = 12'h000;
    logic [1:0]   htrans = 2'h0;
    logic [4:0]   unc_first_pos = 5'h00;
    logic [31:0]  hwdata = 32'h0, hrdata, q;
    logic         hreadyout, hresp, err_msg, ecrc_gen_en, ecrc_chk_en, irq;
    aecer_evt_s   evt = '0;
    logic [127:0] evt_hdr = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    int           n_fail = 0, cmp_count = 0, n_msg, i;
    int           pos [6] = '{0, 6, 7, 8, 12, 13};
    always #20 hclk = ~hclk;
    aecer_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .evt_hdr(evt_hdr),
        .unc_first(unc_first), .unc_first_pos(unc_first_pos), .err_msg(err_msg),
        .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en), .irq(irq));
    aecer_rc_model i_rc (.hclk(hclk), .hresetn(hresetn), .err_msg(err_msg), .n_msg(n_msg));
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // slave may stretch; bounded so a stuck bus ends the run
    task automatic hwait;
        int k;
        @(posedge hclk);
        for (k = 0; hreadyout !== 1'b1; k++) begin
            if (k == 50) begin
                n_fail++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask
    // idle edge after each transfer so reads see fresh data
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hwait();
        q = hrdata;
        @(posedge hclk);
    endtask
    task automatic pulse(input aecer_evt_s e);
        evt <= e;
        @(posedge hclk);
        evt <= '0;
        @(posedge hclk);
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("status rst", q, STATUS_RST);
        xfer(1'b0, OFF_MASK, 32'h0);
        chk("mask rst", q, MASK_RST);
        xfer(1'b0, OFF_CAPCTL, 32'h0);
        chk("capctl rst", q, 32'h0000_00a0);
        xfer(1'b0, OFF_UNC_STAT, 32'h0);
        chk("unmapped", q, 32'h0);
        for (i = 0; i < 6; i++) begin
            pulse(aecer_evt_s'(6'h20 >> i));
            xfer(1'b0, OFF_STATUS, 32'h0);
            chk("status set", q, 32'h1 << pos[i]);
            xfer(1'b1, OFF_STATUS, 32'h1 << pos[i]);
            xfer(1'b0, OFF_STATUS, 32'h0);
            chk("status clr", q, 32'h0);
        end
        chk("messages", n_msg, 32'd5);
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, OFF_HDR0 + 12'(4 * i), 32'h0);
            chk("header", q, evt_hdr[127 - 32 * i -: 32]);
        end
        xfer(1'b1, OFF_MASK, 32'hffff_ffff);
        xfer(1'b0, OFF_MASK, 32'h0);
        chk("mask rw", q, COR_IMPL);
        pulse(aecer_evt_s'(6'h3f));
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("status masked", q, COR_IMPL);
        chk("masked msgs", n_msg, 32'd5);
        unc_first <= 1'b1;
        unc_first_pos <= 5'h13;
        @(posedge hclk);
        unc_first_pos <= 5'h03;
        @(posedge hclk);
        unc_first <= 1'b0;
        xfer(1'b1, OFF_CAPCTL, 32'hffff_ffff);
        xfer(1'b0, OFF_CAPCTL, 32'h0);
        chk("capctl rw", q, 32'h0000_01f3);
        chk("ecrc en", 32'({ecrc_gen_en, ecrc_chk_en}), 32'h3);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        xfer(1'b1, OFF_IRQ_MASK, 32'h0000_0040);
        pulse(aecer_evt_s'(6'h21));
        chk("irq masked", irq, 32'h0);
        pulse(aecer_evt_s'(6'h10));
        chk("irq on", irq, 32'h1);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("irq status", q, 32'h0000_2041);
        @(posedge hclk);
        chk("irq clr", irq, 32'h0);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        summarize();
    end
endmodule
bind aecer_regs aecer_regs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .err_msg(err_msg),
    .ecrc_gen_en(ecrc_gen_en), .irq(irq));
`default_nettype wire
